/* rps_top.sv */
// Our own choice: strobed register access.
`timescale 1ns/1ps

module rps_top
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire rps_pkg::rps_sfr_req_s sfr_req,
    output logic [7:0] sfr_rdata,
    input wire rps_pkg::rps_bit_req_s bit_req,
    output logic bit_rdata,
    input wire rps_pkg::rps_rst_s rst_req,
    input wire logic wake_pin,
    input wire logic resume_pin,
    output rps_pkg::rps_ctl_s ctl
);
    import rps_pkg::*;

    // Scratch store and control state
    logic [7:0] scr_q [0:SCR_COUNT-1];
    logic [7:0] psc_q;
    logic [7:0] psc_d;
    rps_state_e state_q;
    rps_state_e state_d;

    // Pin synchronisers and edge detectors
    logic wake_s1_q;
    logic wake_s2_q;
    logic wake_s3_q;
    logic resume_s1_q;
    logic resume_s2_q;
    logic resume_s3_q;
    logic wake_evt;
    logic resume_evt;

    // Merged write path
    logic [7:0] bit_byte;
    logic [BIT_IDX_W-1:0] bit_idx;
    logic [7:0] bit_mask;
    logic [7:0] bit_src;
    logic bit_ok;
    logic bit_wr;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [4:0] wr_hit;
    logic [7:0] psc_wr;
    logic scr_we;

    // Hardware clear strobes and control write select
    logic wake_clr;
    logic resume_clr;
    logic psc_sel;

    // Read path
    logic [7:0] rdata_q;
    logic bit_rdata_q;

    // Finds the scratch number for a byte address; top bit flags a hit
    function automatic logic [4:0] scr_lookup(input logic [7:0] a);
        logic [4:0] r;
        r = '0;
        for (int i = 0; i < SCR_COUNT; i++)
        begin
            if (a == SCR_ADDR[i])
            begin
                r = {1'b1, i[SCR_IDX_W-1:0]};
            end
        end
        return r;
    endfunction

    // True for the bytes that accept single-bit operations
    function automatic logic bit_capable(input logic [7:0] a);
        logic r;
        r = (a == PSC_ADDR);
        for (int i = 0; i < SCR_BITADDR_COUNT; i++)
        begin
            if (a == SCR_ADDR[i])
            begin
                r = 1'b1;
            end
        end
        return r;
    endfunction

    // Byte read mux shared by byte reads and bit tests
    function automatic logic [7:0] read_byte(input logic [7:0] a);
        logic [4:0] h;
        logic [7:0] r;
        h = scr_lookup(a);
        r = READ_IDLE;
        if (h[SCR_IDX_W])
        begin
            r = scr_q[h[SCR_IDX_W-1:0]];
        end
        else if (a == PSC_ADDR)
        begin
            r = psc_q & PSC_RW_MASK;
        end
        return r;
    endfunction

    // Wake and resume pins cross into the clock domain
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wake_s1_q <= 1'b0;
            wake_s2_q <= 1'b0;
            wake_s3_q <= 1'b0;
        end
        else
        begin
            wake_s1_q <= wake_pin;
            wake_s2_q <= wake_s1_q;
            wake_s3_q <= wake_s2_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            resume_s1_q <= 1'b0;
            resume_s2_q <= 1'b0;
            resume_s3_q <= 1'b0;
        end
        else
        begin
            resume_s1_q <= resume_pin;
            resume_s2_q <= resume_s1_q;
            resume_s3_q <= resume_s2_q;
        end
    end

    // Rising edges become one-cycle events
    assign wake_evt = wake_s2_q & ~wake_s3_q;
    assign resume_evt = resume_s2_q & ~resume_s3_q;

    // Bit address splits into its byte and the bit within it
    always_comb
    begin
        bit_byte = bit_req.addr & BIT_BYTE_MASK;
        bit_idx = bit_req.addr[BIT_IDX_W-1:0];
        bit_mask = 8'h01 << bit_idx;
        bit_src = read_byte(bit_byte);
        bit_ok = bit_capable(bit_byte);
    end

    // Bit operations become a read-modify-write of their byte
    always_comb
    begin
        bit_wr = (bit_req.set | bit_req.clr) & bit_ok & ~sfr_req.wr;
        wr_en = sfr_req.wr | bit_wr;
        if (sfr_req.wr)
        begin
            wr_addr = sfr_req.addr;
            wr_data = sfr_req.wdata;
        end
        else
        begin
            wr_addr = bit_byte;
            if (bit_req.set)
            begin
                wr_data = bit_src | bit_mask;
            end
            else
            begin
                wr_data = bit_src & ~bit_mask;
            end
        end
        wr_hit = scr_lookup(wr_addr);
    end

    // Scratch write strobe for a mapped byte address
    assign scr_we = wr_en & wr_hit[SCR_IDX_W];

    // Scratch bytes have no reset of any kind
    always_ff @(posedge ref_clk)
    begin
        if (scr_we)
        begin
            scr_q[wr_hit[SCR_IDX_W-1:0]] <= wr_data;
        end
    end

    // Keep only the strongest state request of a control write
    always_comb
    begin
        psc_wr = wr_data & PSC_RW_MASK;
        if (psc_wr[PSC_PD_BIT])
        begin
            psc_wr[PSC_TS_BIT] = 1'b0;
            psc_wr[PSC_IDLE_BIT] = 1'b0;
        end
        else if (psc_wr[PSC_TS_BIT])
        begin
            psc_wr[PSC_IDLE_BIT] = 1'b0;
        end
    end

    // Hardware clears on wakeup and resume, and the write select
    assign wake_clr = wake_evt
        && (state_q == RPS_PDOWN || state_q == RPS_TSHUT);
    assign resume_clr = resume_evt && (state_q == RPS_IDLE);
    assign psc_sel = wr_en && (wr_addr == PSC_ADDR);

    // Next value of the control register
    always_comb
    begin
        psc_d = psc_q;
        if (wake_clr)
        begin
            psc_d = psc_q & ~PSC_WAKE_CLR_MASK;
        end
        else if (resume_clr)
        begin
            psc_d[PSC_IDLE_BIT] = 1'b0;
        end
        // A software write in the same cycle wins over the clear
        if (psc_sel)
        begin
            psc_d = psc_wr;
        end
    end

    // Control register clears on every reset except wakeup
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            psc_q <= PSC_RESET;
        end
        else if (rst_req.sys || rst_req.sw)
        begin
            psc_q <= PSC_RESET;
        end
        else
        begin
            psc_q <= psc_d;
        end
    end

    // System controller state walk
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            RPS_RUN:
            begin
                if (psc_q[PSC_PD_BIT])
                begin
                    state_d = RPS_PDOWN;
                end
                else if (psc_q[PSC_TS_BIT])
                begin
                    state_d = RPS_TSHUT;
                end
                else if (psc_q[PSC_IDLE_BIT])
                begin
                    state_d = RPS_IDLE;
                end
            end
            RPS_IDLE:
            begin
                if (resume_evt)
                begin
                    state_d = RPS_RUN;
                end
            end
            RPS_PDOWN:
            begin
                if (wake_evt)
                begin
                    state_d = RPS_RUN;
                end
            end
            RPS_TSHUT:
            begin
                if (wake_evt)
                begin
                    state_d = RPS_RUN;
                end
            end
            default:
            begin
                state_d = RPS_RUN;
            end
        endcase
    end

    // State register; system and software resets return it to run
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= RPS_RUN;
        end
        else if (rst_req.sys || rst_req.sw)
        begin
            state_q <= RPS_RUN;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Byte read data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rdata_q <= READ_IDLE;
        end
        else if (sfr_req.rd)
        begin
            rdata_q <= read_byte(sfr_req.addr);
        end
        else
        begin
            rdata_q <= READ_IDLE;
        end
    end

    // Bit test result, zero for bytes without bit access
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bit_rdata_q <= 1'b0;
        end
        else if (bit_req.rd && bit_ok)
        begin
            bit_rdata_q <= bit_src[bit_idx];
        end
        else
        begin
            bit_rdata_q <= 1'b0;
        end
    end

    // Registered read data to the ports
    assign sfr_rdata = rdata_q;
    assign bit_rdata = bit_rdata_q;

    // Controls toward oscillator, test logic and core
    always_comb
    begin
        ctl.state = state_q;
        ctl.xosc_en = psc_q[PSC_XOSC_BIT];
        ctl.test_mode = psc_q[PSC_FTM_BIT];
        ctl.cpu_halt = (state_q != RPS_RUN);
    end

endmodule

/* rps_pkg.sv */
package rps_pkg;

    // Register widths and counts
    localparam int DATA_W = 8;
    localparam int SCR_COUNT = 16;
    localparam int SCR_IDX_W = 4;
    localparam int BIT_IDX_W = 3;

    // Retained scratch byte addresses, indexed by scratch number
    localparam logic [7:0] SCR_ADDR [0:SCR_COUNT-1] = '{
        8'hB8, 8'hB0, 8'hA8, 8'hF1, 8'hF2, 8'hF3, 8'hF5, 8'hF6,
        8'hF7, 8'hF9, 8'hFA, 8'hFB, 8'hFC, 8'hFD, 8'hFE, 8'hFF
    };
    // Scratch numbers below this one sit at bit-addressable offsets
    localparam int SCR_BITADDR_COUNT = 3;

    // Power state control register
    localparam logic [7:0] PSC_ADDR = 8'hF8;
    localparam logic [7:0] PSC_RESET = 8'h00;
    localparam logic [7:0] PSC_RW_MASK = 8'hF8;
    localparam logic [7:0] PSC_WAKE_CLR_MASK = 8'hF0;
    localparam int PSC_PD_BIT = 7;
    localparam int PSC_TS_BIT = 6;
    localparam int PSC_IDLE_BIT = 5;
    localparam int PSC_XOSC_BIT = 4;
    localparam int PSC_FTM_BIT = 3;

    // Bit address split: upper bits name the byte, low bits the bit
    localparam logic [7:0] BIT_BYTE_MASK = 8'hF8;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // System controller states
    typedef enum logic [3:0] {
        RPS_RUN = 4'b0001,
        RPS_IDLE = 4'b0010,
        RPS_PDOWN = 4'b0100,
        RPS_TSHUT = 4'b1000
    } rps_state_e;

    // Byte access request from the controller core
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rps_sfr_req_s;

    // Single-bit access request
    typedef struct packed {
        logic [7:0] addr;
        logic set;
        logic clr;
        logic rd;
    } rps_bit_req_s;

    // Resets other than power-on
    typedef struct packed {
        logic sys;
        logic sw;
    } rps_rst_s;

    // Controls toward the rest of the chip
    typedef struct packed {
        rps_state_e state;
        logic xosc_en;
        logic test_mode;
        logic cpu_halt;
    } rps_ctl_s;

endpackage

/* rps_top_monitor.sv */
`timescale 1ns/1ps

module rps_top_monitor
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire rps_pkg::rps_sfr_req_s sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire rps_pkg::rps_bit_req_s bit_req,
    input wire logic bit_rdata,
    input wire rps_pkg::rps_rst_s rst_req,
    input wire logic wake_pin,
    input wire logic resume_pin,
    input wire rps_pkg::rps_ctl_s ctl
);
    import rps_pkg::*;
    logic psc_wr;
    logic quiet;

    // Clean control write taken while running
    assign quiet = !rst_req.sys && !rst_req.sw;
    assign psc_wr = sfr_req.wr && sfr_req.addr == PSC_ADDR && quiet
        && ctl.state == RPS_RUN;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    // Read paths rest at zero
    chk_rdata_idle: assert property (
        !$past(sfr_req.rd) |-> sfr_rdata == READ_IDLE)
        else $error("byte read data not idle");
    chk_bit_idle: assert property (
        !$past(bit_req.rd) |-> !bit_rdata)
        else $error("bit read data not idle");
    // State requests with priority, control bits, halt decode and reset
    chk_pd_entry: assert property (
        psc_wr && sfr_req.wdata[PSC_PD_BIT] |-> ##2 ctl.state == RPS_PDOWN)
        else $error("power down not entered");
    chk_ts_entry: assert property (
        psc_wr && sfr_req.wdata[7:6] == 2'b01 |-> ##2 ctl.state == RPS_TSHUT)
        else $error("thermal shutdown not entered");
    chk_idle_entry: assert property (
        psc_wr && sfr_req.wdata[7:5] == 3'b001 |-> ##2 ctl.state == RPS_IDLE)
        else $error("idle not entered");
    chk_xosc_on: assert property (
        psc_wr && sfr_req.wdata[7:4] == 4'h1 |-> ##[1:2] ctl.xosc_en)
        else $error("oscillator enable not set");
    chk_test_on: assert property (
        psc_wr && sfr_req.wdata[7:3] == 5'h01 |-> ##[1:2] ctl.test_mode)
        else $error("test mode not set");
    chk_halt_decode: assert property (
        $onehot(ctl.state) && ctl.cpu_halt == (ctl.state != RPS_RUN))
        else $error("halt does not follow state");
    chk_reset_ctl: assert property (
        !quiet |=> ctl.state == RPS_RUN && !ctl.xosc_en && !ctl.test_mode)
        else $error("controls not cleared by reset");
    // Power down holds until its event; wake and resume return to run
    chk_pd_hold: assert property (
        (!wake_pin) [*4] ##0 (ctl.state == RPS_PDOWN && quiet)
        |=> ctl.state == RPS_PDOWN)
        else $error("power down left without wake");
    chk_wake_run: assert property (
        $rose(wake_pin) && ctl.state inside {RPS_PDOWN, RPS_TSHUT}
        |-> ##[1:6] ctl.state == RPS_RUN)
        else $error("wake did not return to run");
    chk_resume_run: assert property (
        $rose(resume_pin) && ctl.state == RPS_IDLE
        |-> ##[1:6] ctl.state == RPS_RUN)
        else $error("resume did not return to run");
endmodule

bind rps_top rps_top_monitor u_mon (.ref_clk(ref_clk), .rstn(rstn),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .bit_req(bit_req),
    .bit_rdata(bit_rdata), .rst_req(rst_req), .wake_pin(wake_pin),
    .resume_pin(resume_pin), .ctl(ctl));

/* tb_rps_top.sv */
`timescale 1ns/1ps

module tb_rps_top;
    import rps_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    rps_sfr_req_s sfr_req = '0;
    rps_bit_req_s bit_req = '0;
    rps_rst_s rst_req = '0;
    logic wake_pin = 1'b0;
    logic resume_pin = 1'b0;
    logic [7:0] sfr_rdata;
    logic bit_rdata;
    rps_ctl_s ctl;
    int errors = 0;
    int checked = 0;
    logic [7:0] shadow [0:SCR_COUNT-1];

    // Clock at 25 MHz
    always #20 ref_clk = ~ref_clk;

    rps_top DUT (.ref_clk(ref_clk), .rstn(rstn), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .bit_req(bit_req), .bit_rdata(bit_rdata),
        .rst_req(rst_req), .wake_pin(wake_pin), .resume_pin(resume_pin),
        .ctl(ctl));

    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
        input string what);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Byte write, one strobe cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfr_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        sfr_req.wr <= 1'b0;
    endtask

    // Byte read, data taken in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        sfr_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        sfr_req.rd <= 1'b0;
        #1 check(sfr_rdata, exp, "sfr_rdata");
    endtask

    // Bit operation: op 0 set, 1 clear, 2 read
    task automatic bop(input logic [7:0] a, input int op, input logic exp);
        @(posedge ref_clk);
        bit_req <= '{addr: a, set: op == 0, clr: op == 1, rd: op == 2};
        @(posedge ref_clk);
        bit_req <= '0;
        #1 if (op == 2) check(8'(bit_rdata), 8'(exp), "bit_rdata");
    endtask

    // Whole scratch bank against its shadow
    task automatic rd_all();
        for (int i = 0; i < SCR_COUNT; i++)
            rd(SCR_ADDR[i], shadow[i]);
    endtask

    // Raise wake or resume and wait for run
    task automatic wake_up(input logic res);
        int n;
        @(posedge ref_clk);
        if (res)
            resume_pin <= 1'b1;
        else
            wake_pin <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge ref_clk);
            #1;
            if (ctl.state === RPS_RUN)
                break;
        end
        if (n == 20)
        begin
            errors++;
            print_verdict();
        end
        @(posedge ref_clk);
        wake_pin <= 1'b0;
        resume_pin <= 1'b0;
    endtask

    // Every scratch byte distinct, plus a hole in the map
    task automatic t_scratch();
        for (int i = 0; i < SCR_COUNT; i++)
        begin
            shadow[i] = 8'(i * 8'h11) ^ 8'h5A;
            wr(SCR_ADDR[i], shadow[i]);
        end
        rd_all();
        wr(8'hF4, 8'h55);
        rd(8'hF4, 8'h00);
        $display("t_scratch done");
    endtask

    // System and software resets keep scratch, clear control
    task automatic t_resets();
        for (int k = 0; k < 2; k++)
        begin
            wr(PSC_ADDR, 8'h18);
            @(posedge ref_clk);
            rst_req <= '{sys: k == 0, sw: k == 1};
            @(posedge ref_clk);
            rst_req <= '0;
            rd(PSC_ADDR, PSC_RESET);
            rd_all();
        end
        $display("t_resets done");
    endtask

    // Bit set, clear, test on the bit-addressable bytes
    task automatic t_bits();
        logic [7:0] a;
        for (int k = 0; k < SCR_BITADDR_COUNT; k++)
        begin
            a = SCR_ADDR[k];
            wr(a, 8'h00);
            bop(a | 8'h05, 0, 1'b0);
            bop(a | 8'h05, 2, 1'b1);
            rd(a, 8'h20);
            bop(a | 8'h05, 1, 1'b0);
            rd(a, 8'h00);
            shadow[k] = 8'h00;
        end
        bop(8'hF1, 0, 1'b0);
        bop(8'hF1, 2, 1'b0);
        rd(SCR_ADDR[3], shadow[3]);
        bop(PSC_ADDR | 8'h03, 0, 1'b0);
        check(8'(ctl.test_mode), 8'h01, "test_mode");
        bop(PSC_ADDR | 8'h03, 2, 1'b1);
        bop(PSC_ADDR | 8'h03, 1, 1'b0);
        rd(PSC_ADDR, PSC_RESET);
        $display("t_bits done");
    endtask

    // Each request, two mixed requests, then wake and clear
    task automatic t_state();
        logic [7:0] wd [5] = '{8'h98, 8'h58, 8'h28, 8'hF8, 8'h78};
        logic [7:0] sv [5] = '{8'h98, 8'h58, 8'h28, 8'h98, 8'h58};
        rps_state_e st [5] = '{RPS_PDOWN, RPS_TSHUT, RPS_IDLE, RPS_PDOWN,
            RPS_TSHUT};
        for (int i = 0; i < 5; i++)
        begin
            wr(PSC_ADDR, wd[i]);
            repeat (2) @(posedge ref_clk);
            #1 check(8'(ctl.state), 8'(st[i]), "state");
            check(8'(ctl.cpu_halt), 8'h01, "cpu_halt");
            rd(PSC_ADDR, sv[i]);
            wake_up(i == 2);
            rd(PSC_ADDR, 8'h08);
            check(8'(ctl.test_mode), 8'h01, "test_mode");
            rd(SCR_ADDR[3], shadow[3]);
        end
        wr(PSC_ADDR, 8'h10);
        @(posedge ref_clk);
        #1 check(8'(ctl.xosc_en), 8'h01, "xosc_en");
        check(8'(ctl.test_mode), 8'h00, "test_mode");
        wr(PSC_ADDR, 8'h0A);
        rd(PSC_ADDR, 8'h08);
        check(8'(ctl.xosc_en), 8'h00, "xosc_en");
        $display("t_state done");
    endtask

    // Main sequence
    initial
    begin
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        t_scratch();
        t_resets();
        t_bits();
        t_state();
        print_verdict();
    end
endmodule
